// ### hdl/ebiopc_port.sv
// Summary of operation
// - direction bit 0 drives the pin from the output latch, analog or not
// - direction bit 1 shows the pin level; analog selection blocks it
// - after reset pins 0-3 and 5 are analog; output drive unaffected
// - pin 4 resets as digital input and always feeds the timer clock
// - comparator reference output disables pin 2 digital output and input
// - 80-pin parts with mux bit 0 give pins 4-5 to the parallel port
// - external-clock and first internal modes put cycle clock on pin 6
// - external-clock and crystal modes give pins 6-7 to the oscillator
// - oscillator-select bit set disables digital functions of pins 6-7
// - bits 7-6 of level, latch, direction exist only with select bit 0
// - analog select shares an address, reached only when select bit is 1
// - analog select bit 5 reads zero; bits 0-4, when clear, pick analog for pins 0-3 and 5, bits 7-6 pick none
// - internal modes free pin 7; pin 6 is I/O or cycle clock by mode
//
// Decided for this implementation: the address map and the plain strobed port.
`timescale 1ns/1ps
module ebiopc_port #(
  parameter bit VARIANT_80PIN = 1'b1
) (
  // clock and control
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  // register port
  input wire logic [ebiopc_pkg::ADDR_W-1:0] addr_in,
  input wire logic [ebiopc_pkg::DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [ebiopc_pkg::DATA_W-1:0] rdata_out,
  // port pins
  input wire logic [ebiopc_pkg::DATA_W-1:0] pad_level_in,
  output logic [ebiopc_pkg::DATA_W-1:0] pad_drive_out,
  output logic [ebiopc_pkg::DATA_W-1:0] pad_oe_out,
  // parallel port data bits four and five
  input wire logic [1:0] pp_data_drive_in,
  input wire logic [1:0] pp_data_oe_in,
  output logic [1:0] pp_data_level_out,
  // peripheral taps
  output logic timer_zero_clock_in_out,
  output logic [ebiopc_pkg::DATA_W-1:0] analog_en_out,
  output logic comparator_vref_out_en_out,
  output logic osc_pins_owned_out
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [ebiopc_pkg::DATA_W-1:0] output_latch_reg;
  logic [ebiopc_pkg::DATA_W-1:0] direction_control_reg;
  logic [ebiopc_pkg::DATA_W-1:0] analog_select_reg;
  logic [ebiopc_pkg::DATA_W-1:0] shared_default_reg;
  logic [ebiopc_pkg::DATA_W-1:0] watchdog_control_reg;
  logic [ebiopc_pkg::DATA_W-1:0] config_reg;
  logic [ebiopc_pkg::DATA_W-1:0] pin_level_reg;
  logic [ebiopc_pkg::DATA_W-1:0] rdata_reg;
  logic [ebiopc_pkg::DATA_W-1:0] analog_en_reg;
  logic [ebiopc_pkg::CYC_CNT_W-1:0] cyc_cnt_reg;
  logic timer_clk_reg;
  logic [1:0] pp_level_reg;
  logic comparator_vref_out_en_reg;
  logic osc_owned_reg;

  // ----------------------------------------------------------------
  // decoded configuration
  // ----------------------------------------------------------------
  ebiopc_pkg::ebiopc_osc_mode_e osc_mode;
  logic osc_select_cfg;
  logic parallel_port_mux_cfg;
  logic comparator_vref_out_on;
  logic shared_addr_select;
  logic pp_active;
  logic cycle_clock_out;
  logic cyc_clk_on_pin6;
  logic [ebiopc_pkg::DATA_W-1:0] hi_mask;
  logic [ebiopc_pkg::DATA_W-1:0] pin_is_analog;
  logic [ebiopc_pkg::DATA_W-1:0] digital_in_en;
  logic [ebiopc_pkg::DATA_W-1:0] drive_oe;
  logic [ebiopc_pkg::DATA_W-1:0] drive_val;
  logic [ebiopc_pkg::DATA_W-1:0] rd_value;

  ebiopc_pad_if pads ();

  assign osc_mode = ebiopc_pkg::ebiopc_osc_mode_e'(
    config_reg[ebiopc_pkg::CFG_OSC_MSB:ebiopc_pkg::CFG_OSC_LSB]);
  assign osc_select_cfg = config_reg[ebiopc_pkg::OSC_SEL_BIT];
  assign parallel_port_mux_cfg = config_reg[ebiopc_pkg::CFG_PPMUX_BIT];
  assign comparator_vref_out_on = config_reg[ebiopc_pkg::CFG_COMPARATOR_VREF_OUT_BIT];
  assign shared_addr_select =
    watchdog_control_reg[ebiopc_pkg::WDC_SHARED_SEL_BIT];
  assign pp_active = VARIANT_80PIN && !parallel_port_mux_cfg;
  assign cycle_clock_out = cyc_cnt_reg[ebiopc_pkg::CYC_CNT_W-1];
  // top pins only exist when the oscillator does not own them
  assign hi_mask = osc_select_cfg ? ebiopc_pkg::HI_PINS_MASK
                                  : ebiopc_pkg::ALL_ONES;

  // ----------------------------------------------------------------
  // cycle clock mode on pin 6
  // ----------------------------------------------------------------
  always_comb
  begin
    case (osc_mode)
      ebiopc_pkg::OSC_EC,
      ebiopc_pkg::OSC_ECPLL,
      ebiopc_pkg::OSC_INTIO1,
      ebiopc_pkg::OSC_INTPLL1: cyc_clk_on_pin6 = 1'b1;
      ebiopc_pkg::OSC_HS,
      ebiopc_pkg::OSC_HSPLL,
      ebiopc_pkg::OSC_INTIO2,
      ebiopc_pkg::OSC_INTPLL2: cyc_clk_on_pin6 = 1'b0;
      default: cyc_clk_on_pin6 = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // analog map: select bit 4 belongs to pin 5, pin 4 has no channel
  // ----------------------------------------------------------------
  always_comb
  begin
    pin_is_analog = ebiopc_pkg::ALL_ZERO;
    pin_is_analog[3:0] = ~analog_select_reg[3:0];
    pin_is_analog[ebiopc_pkg::PIN_AN_HI] =
      ~analog_select_reg[ebiopc_pkg::ANSEL_PIN5_BIT];
  end

  // ----------------------------------------------------------------
  // per-pin function resolution
  // ----------------------------------------------------------------
  always_comb
  begin
    // analog selection never gates the output driver
    drive_oe = ~direction_control_reg;
    drive_val = output_latch_reg;
    digital_in_en = direction_control_reg & ~pin_is_analog;
    // timer tap is taken regardless of direction, so pin 4 input stays
    if (comparator_vref_out_on)
    begin
      drive_oe[ebiopc_pkg::PIN_VREF_LO] = 1'b0;
      digital_in_en[ebiopc_pkg::PIN_VREF_LO] = 1'b0;
    end
    if (pp_active)
    begin
      drive_oe[ebiopc_pkg::PIN_PP_LO+1:ebiopc_pkg::PIN_PP_LO] =
        pp_data_oe_in;
      drive_val[ebiopc_pkg::PIN_PP_LO+1:ebiopc_pkg::PIN_PP_LO] =
        pp_data_drive_in;
    end
    if (osc_select_cfg)
    begin
      // oscillator or external clock owns both top pins
      drive_oe[ebiopc_pkg::PIN_CLK_IN] = 1'b0;
      drive_oe[ebiopc_pkg::PIN_CLK_OUT] = 1'b0;
      digital_in_en[ebiopc_pkg::PIN_CLK_IN] = 1'b0;
      digital_in_en[ebiopc_pkg::PIN_CLK_OUT] = 1'b0;
    end
    if (cyc_clk_on_pin6)
    begin
      drive_oe[ebiopc_pkg::PIN_CLK_OUT] = 1'b1;
      drive_val[ebiopc_pkg::PIN_CLK_OUT] = cycle_clock_out;
      digital_in_en[ebiopc_pkg::PIN_CLK_OUT] = 1'b0;
    end
  end

  assign pads.drive_oe = drive_oe;
  assign pads.drive_val = drive_val;

  // ----------------------------------------------------------------
  // cycle clock divider, oscillator rate over four
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
      cyc_cnt_reg <= '0;
    else if (ce_in)
      cyc_cnt_reg <= cyc_cnt_reg + 1'b1;
  end

  // ----------------------------------------------------------------
  // output latch: written through either the latch or level address
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
      output_latch_reg <= ebiopc_pkg::LATCH_RST;
    else if (ce_in && wr_in &&
             (addr_in == ebiopc_pkg::OFS_OUTPUT_LATCH ||
              addr_in == ebiopc_pkg::OFS_PIN_LEVEL))
      output_latch_reg <= (wdata_in & hi_mask) |
                          (output_latch_reg & ~hi_mask);
  end

  // ----------------------------------------------------------------
  // direction control
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
      direction_control_reg <= ebiopc_pkg::DIR_RST;
    else if (ce_in && wr_in && addr_in == ebiopc_pkg::OFS_DIRECTION)
      direction_control_reg <= (wdata_in & hi_mask) |
                               (direction_control_reg & ~hi_mask);
  end

  // ----------------------------------------------------------------
  // shared address: analog select or the default register behind it
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
      analog_select_reg <= ebiopc_pkg::ANSEL_RST;
    else if (ce_in && wr_in && addr_in == ebiopc_pkg::OFS_SHARED &&
             shared_addr_select)
      analog_select_reg <= wdata_in & ebiopc_pkg::ANSEL_MASK;
  end

  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
      shared_default_reg <= ebiopc_pkg::SHARED_DEF_RST;
    else if (ce_in && wr_in && addr_in == ebiopc_pkg::OFS_SHARED &&
             !shared_addr_select)
      shared_default_reg <= wdata_in;
  end

  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
      watchdog_control_reg <= ebiopc_pkg::WDC_RST;
    else if (ce_in && wr_in && addr_in == ebiopc_pkg::OFS_WATCHDOG)
      watchdog_control_reg <= wdata_in;
  end

  // ----------------------------------------------------------------
  // configuration: oscillator mode, parallel mux, reference output
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
      config_reg <= ebiopc_pkg::CFG_RST;
    else if (ce_in && wr_in && addr_in == ebiopc_pkg::OFS_CONFIG)
      config_reg <= wdata_in & ebiopc_pkg::CFG_WMASK;
  end

  // ----------------------------------------------------------------
  // pin level capture; disabled inputs read as zero
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
      pin_level_reg <= ebiopc_pkg::ALL_ZERO;
    else if (ce_in)
      pin_level_reg <= pads.pin_sync & digital_in_en;
  end

  // ----------------------------------------------------------------
  // read mux; data valid only in the cycle after the strobe
  // ----------------------------------------------------------------
  always_comb
  begin
    case (addr_in)
      ebiopc_pkg::OFS_PIN_LEVEL:
        rd_value = pin_level_reg & hi_mask;
      ebiopc_pkg::OFS_OUTPUT_LATCH:
        rd_value = output_latch_reg & hi_mask;
      ebiopc_pkg::OFS_DIRECTION:
        rd_value = direction_control_reg & hi_mask;
      ebiopc_pkg::OFS_SHARED:
        rd_value = shared_addr_select ? analog_select_reg
                                      : shared_default_reg;
      ebiopc_pkg::OFS_WATCHDOG:
        rd_value = watchdog_control_reg;
      ebiopc_pkg::OFS_CONFIG:
        rd_value = config_reg;
      default:
        rd_value = ebiopc_pkg::ALL_ZERO;
    endcase
  end

  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
      rdata_reg <= ebiopc_pkg::ALL_ZERO;
    else if (ce_in)
      rdata_reg <= rd_in ? rd_value : ebiopc_pkg::ALL_ZERO;
  end

  // ----------------------------------------------------------------
  // peripheral taps
  // ----------------------------------------------------------------
  // timer input ignores direction and analog selection alike
  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
      timer_clk_reg <= 1'b0;
    else if (ce_in)
      timer_clk_reg <= pads.pin_sync[ebiopc_pkg::PIN_TIMER];
  end

  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
      pp_level_reg <= 2'h0;
    else if (ce_in)
      pp_level_reg <= pp_active ?
        pads.pin_sync[ebiopc_pkg::PIN_PP_LO+1:ebiopc_pkg::PIN_PP_LO] :
        2'h0;
  end

  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      analog_en_reg <= ebiopc_pkg::ALL_ZERO;
      comparator_vref_out_en_reg <= 1'b0;
      osc_owned_reg <= 1'b0;
    end
    else if (ce_in)
    begin
      analog_en_reg <= pin_is_analog;
      // pin 2 doubles as the comparator reference output
      comparator_vref_out_en_reg <= comparator_vref_out_on;
      osc_owned_reg <= osc_select_cfg;
    end
  end

  // ----------------------------------------------------------------
  // pad stage
  // ----------------------------------------------------------------
  ebiopc_pad_ctl #(
    .WIDTH(ebiopc_pkg::DATA_W)
  ) u_pad (
    .mclk_in(mclk_in),
    .reset_in(reset_in),
    .ce_in(ce_in),
    .pad_level_in(pad_level_in),
    .pad_drive_out(pad_drive_out),
    .pad_oe_out(pad_oe_out),
    .core(pads.pad)
  );

  assign rdata_out = rdata_reg;
  assign timer_zero_clock_in_out = timer_clk_reg;
  assign pp_data_level_out = pp_level_reg;
  assign analog_en_out = analog_en_reg;
  assign comparator_vref_out_en_out = comparator_vref_out_en_reg;
  assign osc_pins_owned_out = osc_owned_reg;

endmodule

// ### hdl/ebiopc_pkg.sv
package ebiopc_pkg;

  // ----------------------------------------------------------------
  // bus geometry and register offsets
  // ----------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int ADDR_W = 3;
  localparam logic [ADDR_W-1:0] OFS_PIN_LEVEL = 3'h0;
  localparam logic [ADDR_W-1:0] OFS_OUTPUT_LATCH = 3'h1;
  localparam logic [ADDR_W-1:0] OFS_DIRECTION = 3'h2;
  localparam logic [ADDR_W-1:0] OFS_SHARED = 3'h3;
  localparam logic [ADDR_W-1:0] OFS_WATCHDOG = 3'h4;
  localparam logic [ADDR_W-1:0] OFS_CONFIG = 3'h5;

  // ----------------------------------------------------------------
  // reset values and field layouts
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] LATCH_RST = 8'h00;
  localparam logic [DATA_W-1:0] DIR_RST = 8'hFF;
  localparam logic [DATA_W-1:0] ANSEL_RST = 8'h00;
  localparam logic [DATA_W-1:0] ANSEL_MASK = 8'hDF;
  localparam logic [DATA_W-1:0] SHARED_DEF_RST = 8'h00;
  localparam logic [DATA_W-1:0] WDC_RST = 8'h00;
  localparam logic [DATA_W-1:0] CFG_RST = 8'h0F;
  localparam logic [DATA_W-1:0] CFG_WMASK = 8'h1F;
  localparam logic [DATA_W-1:0] HI_PINS_MASK = 8'h3F;
  localparam logic [DATA_W-1:0] ALL_ONES = 8'hFF;
  localparam logic [DATA_W-1:0] ALL_ZERO = 8'h00;
  localparam int WDC_SHARED_SEL_BIT = 4;
  localparam int CFG_OSC_LSB = 0;
  localparam int CFG_OSC_MSB = 2;
  localparam int CFG_PPMUX_BIT = 3;
  localparam int CFG_COMPARATOR_VREF_OUT_BIT = 4;
  localparam int OSC_SEL_BIT = 2;
  localparam int ANSEL_PIN5_BIT = 4;

  // ----------------------------------------------------------------
  // pin roles
  // ----------------------------------------------------------------
  localparam int PIN_VREF_LO = 2;
  localparam int PIN_TIMER = 4;
  localparam int PIN_PP_LO = 4;
  localparam int PIN_AN_HI = 5;
  localparam int PIN_CLK_OUT = 6;
  localparam int PIN_CLK_IN = 7;
  localparam int CYC_CNT_W = 2;

  typedef enum logic [2:0] {
    OSC_INTIO2 = 3'h0,
    OSC_INTIO1 = 3'h1,
    OSC_INTPLL2 = 3'h2,
    OSC_INTPLL1 = 3'h3,
    OSC_HS = 3'h4,
    OSC_HSPLL = 3'h5,
    OSC_EC = 3'h6,
    OSC_ECPLL = 3'h7
  } ebiopc_osc_mode_e;

endpackage

// ### hdl/ebiopc_pad_if.sv
`timescale 1ns/1ps
interface ebiopc_pad_if;
  logic [ebiopc_pkg::DATA_W-1:0] drive_oe;
  logic [ebiopc_pkg::DATA_W-1:0] drive_val;
  logic [ebiopc_pkg::DATA_W-1:0] pin_sync;

  modport core (output drive_oe, output drive_val, input pin_sync);
  modport pad (input drive_oe, input drive_val, output pin_sync);
endinterface

// ### hdl/ebiopc_pad_ctl.sv
`timescale 1ns/1ps
module ebiopc_pad_ctl #(
  parameter int WIDTH = ebiopc_pkg::DATA_W
) (
  // clock and control
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  // pads
  input wire logic [WIDTH-1:0] pad_level_in,
  output logic [WIDTH-1:0] pad_drive_out,
  output logic [WIDTH-1:0] pad_oe_out,
  // core side
  ebiopc_pad_if.pad core
);

  // ----------------------------------------------------------------
  // per-pin synchroniser and output stage
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_pin
      logic meta_reg;
      logic sync_reg;
      logic drv_reg;
      logic oe_reg;

      // only the second stage is visible to the core
      always_ff @(posedge mclk_in)
      begin
        if (reset_in)
        begin
          meta_reg <= 1'b0;
          sync_reg <= 1'b0;
        end
        else if (ce_in)
        begin
          meta_reg <= pad_level_in[i];
          sync_reg <= meta_reg;
        end
      end

      // registered so the pad sees no combinational glitches
      always_ff @(posedge mclk_in)
      begin
        if (reset_in)
        begin
          drv_reg <= 1'b0;
          oe_reg <= 1'b0;
        end
        else if (ce_in)
        begin
          drv_reg <= core.drive_val[i];
          oe_reg <= core.drive_oe[i];
        end
      end

      assign core.pin_sync[i] = sync_reg;
      assign pad_drive_out[i] = drv_reg;
      assign pad_oe_out[i] = oe_reg;
    end
  endgenerate

endmodule

// ### verif/ebiopc_port_chk.sv
`timescale 1ns/1ps
module ebiopc_port_chk (
  // clock and control
  input wire logic mclk_in,
  input wire logic reset_in,
  // register port
  input wire logic [ebiopc_pkg::ADDR_W-1:0] addr_in,
  input wire logic rd_in,
  input wire logic [ebiopc_pkg::DATA_W-1:0] rdata_out,
  // pins and taps
  input wire logic [ebiopc_pkg::DATA_W-1:0] pad_level_in,
  input wire logic [ebiopc_pkg::DATA_W-1:0] pad_drive_out,
  input wire logic [ebiopc_pkg::DATA_W-1:0] pad_oe_out,
  input wire logic [1:0] pp_data_level_out,
  input wire logic timer_zero_clock_in_out,
  input wire logic [ebiopc_pkg::DATA_W-1:0] analog_en_out,
  input wire logic comparator_vref_out_en_out,
  input wire logic osc_pins_owned_out
);
  // ----------------------------------------------------------------
  // edges since reset release, so pipeline checks skip stale flops
  // ----------------------------------------------------------------
  logic [2:0] age_reg;
  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
      age_reg <= 3'h0;
    else if (age_reg != 3'h7)
      age_reg <= age_reg + 3'h1;
  end

  default clocking @(posedge mclk_in);
  endclocking
  default disable iff (reset_in);

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_rdata_idle;
    !$past(rd_in) |-> rdata_out == 8'h00;
  endproperty
  property p_hi_bits;
    rd_in && osc_pins_owned_out && addr_in <= ebiopc_pkg::OFS_DIRECTION
      |=> rdata_out[7:6] == 2'h0;
  endproperty
  property p_pin7_off;
    osc_pins_owned_out && $past(osc_pins_owned_out) |-> !pad_oe_out[7];
  endproperty
  property p_vref_pin2;
    comparator_vref_out_en_out && $past(comparator_vref_out_en_out)
      |-> !pad_oe_out[2];
  endproperty
  property p_no_analog;
    (analog_en_out & 8'hD0) == 8'h00;
  endproperty
  property p_timer;
    age_reg >= 3'h4 |-> timer_zero_clock_in_out == $past(pad_level_in[4], 3);
  endproperty
  property p_pp_level;
    age_reg >= 3'h4 && pp_data_level_out != 2'h0
      |-> pp_data_level_out == $past(pad_level_in[5:4], 3);
  endproperty
  // leaving the oscillator-owned modes aborts the check rather than faking a phase error
  property p_cyc_clk;
    disable iff (reset_in || !osc_pins_owned_out)
    $rose(pad_drive_out[6]) && pad_oe_out[6] && $past(pad_oe_out[6])
      && $past(osc_pins_owned_out, 2)
      |=> pad_drive_out[6] ##1 !pad_drive_out[6] [*2] ##1 pad_drive_out[6];
  endproperty

  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data present without a read");
  a_hi_bits: assert property (p_hi_bits)
    else $error("upper port bits readable in oscillator mode");
  a_pin7_off: assert property (p_pin7_off)
    else $error("pin 7 driven in oscillator mode");
  a_vref_pin2: assert property (p_vref_pin2)
    else $error("pin 2 driven with reference output on");
  a_no_analog: assert property (p_no_analog)
    else $error("analog flag on a pin without a channel");
  a_timer: assert property (p_timer)
    else $error("timer clock tap does not follow pin 4");
  a_pp_level: assert property (p_pp_level)
    else $error("parallel data level wrong");
  a_cyc_clk: assert property (p_cyc_clk)
    else $error("cycle clock on pin 6 not a divide by four");

  c_read_hi: cover property (rd_in && osc_pins_owned_out);
  c_clk: cover property ($rose(pad_drive_out[6]) && osc_pins_owned_out);
  c_vref: cover property (comparator_vref_out_en_out && !pad_oe_out[2]);
  c_pp: cover property (pp_data_level_out == 2'h3);
endmodule

bind ebiopc_port ebiopc_port_chk ebiopc_port_chk_i (
  .mclk_in(mclk_in), .reset_in(reset_in), .addr_in(addr_in),
  .rd_in(rd_in), .rdata_out(rdata_out), .pad_level_in(pad_level_in),
  .pad_drive_out(pad_drive_out), .pad_oe_out(pad_oe_out),
  .pp_data_level_out(pp_data_level_out),
  .timer_zero_clock_in_out(timer_zero_clock_in_out),
  .analog_en_out(analog_en_out),
  .comparator_vref_out_en_out(comparator_vref_out_en_out),
  .osc_pins_owned_out(osc_pins_owned_out));

// ### verif/ebiopc_pad_model.sv
`timescale 1ns/1ps
module ebiopc_pad_model (
  // clock
  input wire logic mclk_in,
  // device side
  input wire logic [7:0] pad_drive_in,
  input wire logic [7:0] pad_oe_in,
  // external circuit
  input wire logic [7:0] ext_val_in,
  input wire logic ext_en_in,
  // wire level
  output logic [7:0] pad_level_out
);
  // no pull resistors: a pin nobody drives wanders every cycle
  logic [7:0] float_reg = 8'h55;
  always_ff @(posedge mclk_in)
  begin
    float_reg <= ~float_reg;
  end
  always_comb
  begin
    pad_level_out = ext_en_in ? ext_val_in : float_reg;
    pad_level_out = (pad_oe_in & pad_drive_in) | (~pad_oe_in & pad_level_out);
  end
endmodule

// ### verif/ebiopc_port_tb.sv
`timescale 1ns/1ps
module ebiopc_port_tb;
  localparam logic [2:0] LV = ebiopc_pkg::OFS_PIN_LEVEL;
  localparam logic [2:0] LT = ebiopc_pkg::OFS_OUTPUT_LATCH;
  localparam logic [2:0] DR = ebiopc_pkg::OFS_DIRECTION;
  localparam logic [2:0] SH = ebiopc_pkg::OFS_SHARED;
  localparam logic [2:0] WD = ebiopc_pkg::OFS_WATCHDOG;
  localparam logic [2:0] CF = ebiopc_pkg::OFS_CONFIG;
  logic mclk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [2:0] addr_in = 3'h0;
  logic [7:0] wdata_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [1:0] pp_drive = 2'h0;
  logic [1:0] pp_oe = 2'h0;
  logic [7:0] ext_val = 8'hFF;
  logic ext_en = 1'b1;
  logic [7:0] rdata_out, pad_level, pad_drive_out, pad_oe_out, analog_en_out;
  logic [1:0] pp_level;
  logic timer_out, vref_en, osc_owned;
  int miscompares = 0;
  int total_checks = 0;

  always #12.5 mclk_in = ~mclk_in;

  ebiopc_port #(.VARIANT_80PIN(1'b1)) ebiopc_port_i (
    .mclk_in(mclk_in), .reset_in(reset_in), .ce_in(1'b1),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .pad_level_in(pad_level),
    .pad_drive_out(pad_drive_out), .pad_oe_out(pad_oe_out),
    .pp_data_drive_in(pp_drive), .pp_data_oe_in(pp_oe),
    .pp_data_level_out(pp_level), .timer_zero_clock_in_out(timer_out),
    .analog_en_out(analog_en_out), .comparator_vref_out_en_out(vref_en),
    .osc_pins_owned_out(osc_owned));

  ebiopc_pad_model ebiopc_pad_model_i (
    .mclk_in(mclk_in), .pad_drive_in(pad_drive_out),
    .pad_oe_in(pad_oe_out), .ext_val_in(ext_val), .ext_en_in(ext_en),
    .pad_level_out(pad_level));

  // ----------------------------------------------------------------
  // bus and compare helpers
  // ----------------------------------------------------------------
  task automatic chk8(input logic [7:0] g, input logic [7:0] e,
                      input string m);
    total_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge mclk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rdchk(input logic [2:0] a, input logic [7:0] e,
                       input string m);
    @(posedge mclk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    #1;
    chk8(rdata_out, e, m);
  endtask
  task automatic end_test(input string n);
    $display("test %s done: %0d checks, %0d miscompares", n, total_checks,
             miscompares);
  endtask
  task automatic final_report;
    $display("checks %0d, miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    settle(4);
    rdchk(LV, 8'h10, "level at reset");
    rdchk(LT, 8'h00, "latch at reset");
    rdchk(DR, 8'h3F, "direction at reset");
    rdchk(SH, 8'h00, "shared at reset");
    rdchk(WD, 8'h00, "watchdog at reset");
    rdchk(CF, 8'h0F, "config at reset");
    chk8(analog_en_out, 8'h2F, "analog at reset");
    chk8(pad_oe_out & 8'h3F, 8'h00, "inputs at reset");
    end_test("reset");
  endtask
  task automatic t_analog;
    wr(WD, 8'h10);
    rdchk(SH, 8'h00, "analog select reset");
    wr(SH, 8'hFF);
    rdchk(SH, 8'hDF, "analog bit 5");
    settle(1);
    chk8(analog_en_out, 8'h00, "all digital");
    wr(WD, 8'h00);
    rdchk(SH, 8'h00, "default reg");
    wr(SH, 8'h5A);
    rdchk(SH, 8'h5A, "default reg write");
    wr(WD, 8'h10);
    rdchk(SH, 8'hDF, "analog kept");
    wr(SH, 8'h00);
    rdchk(WD, 8'h10, "watchdog reg");
    chk8(analog_en_out, 8'h2F, "analog back");
    wr(WD, 8'h00);
    wr(3'h6, 8'hFF);
    rdchk(3'h6, 8'h00, "unmapped");
    end_test("analog");
  endtask
  task automatic t_output;
    // outputs on analog pins on purpose: drive must be unaffected
    wr(CF, 8'h08);
    wr(DR, 8'h00);
    wr(LT, 8'hA5);
    settle(3);
    chk8(pad_oe_out, 8'hFF, "all driving");
    chk8(pad_drive_out, 8'hA5, "latch drive");
    wr(LV, 8'h3C);
    rdchk(LT, 8'h3C, "level write loads latch");
    settle(2);
    chk8(pad_drive_out, 8'h3C, "drive after level write");
    rdchk(LV, 8'h00, "outputs read low");
    end_test("output");
  endtask
  task automatic t_input;
    wr(DR, 8'hFF);
    ext_val <= 8'h5B;
    wr(WD, 8'h10);
    wr(SH, 8'hFF);
    settle(4);
    chk8(pad_oe_out, 8'h00, "released");
    rdchk(LV, 8'h5B, "digital inputs");
    rdchk(LT, 8'h3C, "latch unaffected");
    wr(SH, 8'h00);
    settle(4);
    rdchk(LV, 8'h50, "analog inputs read 0");
    wr(SH, 8'hFF);
    end_test("input");
  endtask
  task automatic t_osc;
    int ones;
    logic [2:0] m;
    wr(DR, 8'h00);
    wr(LT, 8'hC0);
    for (int i = 0; i < 8; i++)
    begin
      m = i[2:0];
      wr(CF, {5'h01, m});
      settle(3);
      chk8({7'h00, osc_owned}, {7'h00, m[2]}, "osc select");
      chk8(pad_oe_out & 8'hC0, {~m[2], !(m == 3'h4 || m == 3'h5), 6'h00},
           "osc pins");
      ones = 0;
      repeat (8)
      begin
        @(negedge mclk_in);
        ones += pad_drive_out[6];
      end
      if (m != 3'h4 && m != 3'h5)
        chk8(8'(ones), (m[0] || m[2]) ? 8'h04 : 8'h08, "pin 6");
      rdchk(LT, m[2] ? 8'h00 : 8'hC0, "upper latch bits");
    end
    end_test("osc");
  endtask
  task automatic t_comparator_vref_out;
    wr(CF, 8'h18);
    settle(3);
    chk8(pad_oe_out & 8'h04, 8'h00, "pin 2 output off");
    chk8({7'h00, vref_en}, 8'h01, "reference tap");
    wr(DR, 8'hFF);
    ext_val <= 8'h04;
    settle(4);
    rdchk(LV, 8'h00, "pin 2 input off");
    wr(CF, 8'h08);
    settle(4);
    rdchk(LV, 8'h04, "pin 2 input back");
    end_test("comparator_vref_out");
  endtask
  task automatic t_ppmux;
    wr(CF, 8'h00);
    wr(DR, 8'h00);
    pp_drive <= 2'h2;
    pp_oe <= 2'h3;
    settle(3);
    chk8(pad_oe_out & 8'h30, 8'h30, "parallel enable");
    chk8(pad_drive_out & 8'h30, 8'h20, "parallel drive");
    @(posedge mclk_in);
    pp_oe <= 2'h0;
    ext_val <= 8'h30;
    settle(4);
    chk8(pad_oe_out & 8'h30, 8'h00, "direction ignored");
    chk8({6'h00, pp_level}, 8'h03, "parallel input");
    chk8({7'h00, timer_out}, 8'h01, "timer input");
    wr(LT, 8'h10);
    ext_val <= 8'h00;
    wr(CF, 8'h08);
    settle(4);
    chk8({6'h00, pp_level}, 8'h00, "parallel off");
    chk8({7'h00, timer_out}, 8'h01, "timer from output");
    end_test("ppmux");
  endtask

  initial
  begin
    repeat (8) @(posedge mclk_in);
    reset_in <= 1'b0;
    t_reset();
    t_analog();
    t_output();
    t_input();
    t_osc();
    t_comparator_vref_out();
    t_ppmux();
    final_report();
  end

  // the whole run needs well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge mclk_in);
    miscompares++;
    final_report();
  end
endmodule
